// ==== hw/lcr_top.v ====
// Limits configuration register with fault re-arm control.
`timescale 1ns/1ps
`default_nettype none
`include "lcr_defs.vh"
// Function
// [R1] Re-arm zero: stay off after fault.
// [R2] Re-arm one: fast power-up keeping registers.
// [R3] Any register reset sets reset indicator.
// [R4] Host clears indicator to detect resets.
// [R5] Threshold codes select 110 to 140 C.
// [R6] Protocol bit selects single or double write.
// [R7] Forced reset restores defaults, self-clears.
module lcr_top (
	// Clock and reset.
	input  wire       MCLK_I,
	input  wire       RST_N_I,
	// Register access from the serial front end.
	input  wire       WR_I,
	input  wire [7:0] ADDR_I,
	input  wire [7:0] WDATA_I,
	output reg  [7:0] RDATA_O,
	// Fault events from the analog side.
	input  wire       THERMAL_SHUTDOWN_I,
	input  wire       OUTPUT_SHORT_FAULT_I,
	// Power stage control.
	output reg        RUN_O,
	output reg        FAST_POWER_UP_SEQUENCE_O,
	// Decoded settings.
	output reg  [7:0] TWARN_CELSIUS_O,
	output reg  [1:0] PEAK_LIMIT_SEL_O,
	output reg        DOUBLE_WRITE_O
);
	// Data flow: a raw write passes the protocol gate, lands in the
	// register one edge later, and the register drives every setting
	// output through one more flip-flop. The fault state machine reads
	// only the re-arm bit and the two fault levels, and it never writes
	// the register, so a fault cannot disturb the host's setup.

	// Fault handling states, one-hot. OFF is left only through the reset
	// pin, so without re-arm the part stays down until the system acts.
	localparam ST_RUN     = 3'b001;
	localparam ST_OFF     = 3'b010;
	localparam ST_FAST_UP = 3'b100;

	// Gated write handed on by the protocol stage.
	wire       wr_ok;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire       wr_hit;
	// Configuration register and its next value.
	reg  [7:0] limits_configuration_r;
	reg  [7:0] limits_configuration_nxt;
	// Fault state, hold-off counter and their next values.
	reg  [2:0] state_r;
	reg  [2:0] state_nxt;
	reg  [3:0] cnt_r;
	reg  [3:0] cnt_nxt;
	// Next values of the registered outputs.
	reg  [7:0] rdata_nxt;
	reg        run_nxt;
	reg        fast_up_nxt;
	reg  [7:0] twarn_nxt;
	reg  [1:0] peak_lim_nxt;
	reg        dbl_nxt;
	// Field views of the stored register.
	wire       fault_en;
	wire       force_rst;
	wire       dbl_mode;
	wire [1:0] twarn_code;
	wire [1:0] peak_lim_code;
	// Either fault event stops the power stage at once.
	wire       fault;

	// Threshold code to degrees Celsius, ten degrees a step from 110.
	function [7:0] twarn_deg;
		input [1:0] code;
		begin
			case (code)
				2'b00: twarn_deg = `LCR_TWARN_C0;
				2'b01: twarn_deg = `LCR_TWARN_C1;
				2'b10: twarn_deg = `LCR_TWARN_C2;
				default: twarn_deg = `LCR_TWARN_C3;
			endcase
		end
	endfunction

	// Address decode, shared by the write and the read path so the two
	// can never disagree on where the register lives.
	function addr_hit;
		input [7:0] addr;
		begin
			addr_hit = (addr == `LCR_ADDR_LIMCFG);
		end
	endfunction

	// The fault inputs are levels; the state machine looks at them on
	// every edge, so even a one-cycle fault is acted upon.
	assign fault         = THERMAL_SHUTDOWN_I | OUTPUT_SHORT_FAULT_I;

	// Field views, so the logic below reads by meaning, not bit index.
	assign fault_en      = limits_configuration_r[`LCR_BIT_FAULT_EN];
	assign force_rst     = limits_configuration_r[`LCR_BIT_FORCE_RST];
	assign dbl_mode      = limits_configuration_r[`LCR_BIT_DBL_WRITE];
	assign twarn_code    =
		limits_configuration_r[`LCR_MSB_TWARN:`LCR_LSB_TWARN];
	assign peak_lim_code =
		limits_configuration_r[`LCR_MSB_PEAK_LIM:`LCR_LSB_PEAK_LIM];
	assign wr_hit        = wr_ok && addr_hit(wr_addr);

	// Protocol gate. It reads the stored mode bit, so a write that changes
	// the mode only governs the writes that follow it.
	lcr_wrgate u_gate (
		.clk_i   (MCLK_I),
		.rst_n_i (RST_N_I),
		.wr_i    (WR_I),
		.addr_i  (ADDR_I),
		.data_i  (WDATA_I),
		.dbl_i   (dbl_mode),
		.wr_o    (wr_ok),
		.addr_o  (wr_addr),
		.data_o  (wr_data)
	);

	// Next register value. A forced reset is stored for one cycle and then
	// defaults load; it wins over a write in that cycle, so the reset
	// indicator is never lost to a late write.
	always @* begin
		limits_configuration_nxt = limits_configuration_r;
		if (force_rst) begin
			limits_configuration_nxt = `LCR_RESET_VALUE; // R7 R3
		end else if (wr_hit) begin
			limits_configuration_nxt = wr_data; // R4
		end
	end

	// Register storage. A fault never touches it, so fast power-up resumes
	// with the values the host last programmed.
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			limits_configuration_r <= `LCR_RESET_VALUE; // R3
		end else begin
			limits_configuration_r <= limits_configuration_nxt; // R2
		end
	end

	// Fault handling: off for good, or a timed fast power-up that keeps the
	// setup. The hold-off restarts while the fault persists, so the stage
	// only comes back after a full quiet interval.
	always @* begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_RUN: begin
				if (fault) begin
					if (fault_en) begin
						state_nxt = ST_FAST_UP; // R2
						cnt_nxt   = `LCR_FAST_UP_CYCLES;
					end else begin
						state_nxt = ST_OFF; // R1
					end
				end
			end
			ST_OFF: begin
				// No way out but the reset pin.
				state_nxt = ST_OFF; // R1
			end
			ST_FAST_UP: begin
				if (fault) begin
					cnt_nxt = `LCR_FAST_UP_CYCLES;
				end else if (cnt_r == 4'h1) begin
					state_nxt = ST_RUN; // R2
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				// An illegal code falls back to running.
				state_nxt = ST_RUN;
				cnt_nxt   = 4'h0;
			end
		endcase
	end

	// State and counter storage.
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			state_r <= ST_RUN;
			cnt_r   <= 4'h0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// Output next values. Read data follows the address of the previous
	// cycle; an unmapped address reads as zero.
	always @* begin
		rdata_nxt    = 8'h00;
		if (addr_hit(ADDR_I)) begin
			rdata_nxt = limits_configuration_r;
		end
		run_nxt      = (state_r == ST_RUN) && !fault; // R1 R2
		fast_up_nxt  = (state_r == ST_FAST_UP); // R2
		twarn_nxt    = twarn_deg(twarn_code); // R5
		peak_lim_nxt = peak_lim_code;
		dbl_nxt      = dbl_mode; // R6
	end

	// Registered outputs, so no pin is driven through logic.
	always @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			RDATA_O                  <= 8'h00;
			RUN_O                    <= 1'b0;
			FAST_POWER_UP_SEQUENCE_O <= 1'b0;
			TWARN_CELSIUS_O          <= `LCR_TWARN_C0;
			PEAK_LIMIT_SEL_O         <= 2'b00;
			DOUBLE_WRITE_O           <= 1'b0;
		end else begin
			RDATA_O                  <= rdata_nxt;
			RUN_O                    <= run_nxt;
			FAST_POWER_UP_SEQUENCE_O <= fast_up_nxt;
			TWARN_CELSIUS_O          <= twarn_nxt;
			PEAK_LIMIT_SEL_O         <= peak_lim_nxt;
			DOUBLE_WRITE_O           <= dbl_nxt;
		end
	end
endmodule // lcr_top
`default_nettype wire

// ==== hw/lcr_defs.vh ====
// Constants for the limits configuration register block.
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH
`define LCR_ADDR_LIMCFG     8'h0c
`define LCR_BIT_FAULT_EN    0
`define LCR_BIT_RST_IND     1
`define LCR_BIT_FORCE_RST   2
`define LCR_BIT_DBL_WRITE   3
`define LCR_LSB_TWARN       4
`define LCR_MSB_TWARN       5
`define LCR_LSB_PEAK_LIM    6
`define LCR_MSB_PEAK_LIM    7
`define LCR_RESET_VALUE     8'h02
`define LCR_TWARN_C0        8'h6e
`define LCR_TWARN_C1        8'h78
`define LCR_TWARN_C2        8'h82
`define LCR_TWARN_C3        8'h8c
`define LCR_FAST_UP_CYCLES  4'h8
`endif

// ==== hw/lcr_wrgate.v ====
// Write gate: classic single write or double write confirmation.
`timescale 1ns/1ps
`default_nettype none
module lcr_wrgate (
	// Clock and reset.
	input  wire       clk_i,
	input  wire       rst_n_i,
	// Raw write request.
	input  wire       wr_i,
	input  wire [7:0] addr_i,
	input  wire [7:0] data_i,
	input  wire       dbl_i,
	// Accepted write.
	output reg        wr_o,
	output reg  [7:0] addr_o,
	output reg  [7:0] data_o
);
	reg       pend_r;
	reg [7:0] paddr_r;
	reg [7:0] pdata_r;

	// In double mode a write only lands when two identical writes follow.
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			pend_r  <= 1'b0;
			paddr_r <= 8'h00;
			pdata_r <= 8'h00;
			wr_o    <= 1'b0;
			addr_o  <= 8'h00;
			data_o  <= 8'h00;
		end else begin
			wr_o <= 1'b0;
			if (wr_i) begin
				addr_o <= addr_i;
				data_o <= data_i;
				if (!dbl_i) begin
					wr_o   <= 1'b1; // R6
					pend_r <= 1'b0;
				end else if (pend_r && paddr_r == addr_i &&
					pdata_r == data_i) begin
					wr_o   <= 1'b1; // R6
					pend_r <= 1'b0;
				end else begin
					pend_r  <= 1'b1;
					paddr_r <= addr_i;
					pdata_r <= data_i;
				end
			end
		end
	end
endmodule // lcr_wrgate
`default_nettype wire

// ==== bench/lcr_host.sv ====
// Host model that issues register writes.
`timescale 1ns/1ps
`default_nettype none
module lcr_host (
	// Clock and write bus.
	input  wire logic       c_i,
	output var  logic       wr_o,
	output var  logic [7:0] a_o,
	output var  logic [7:0] d_o
);
	initial {wr_o, a_o, d_o} = {1'b0, 8'h0c, 8'h00};
	// One write a call; double mode is met by calling twice.
	task wr(input logic [7:0] a, d);
		@(posedge c_i) #1 {wr_o, a_o, d_o} = {1'b1, a, d};
		@(posedge c_i) #1 {wr_o, a_o} = {1'b0, 8'h0c};
	endtask
endmodule // lcr_host
`default_nettype wire

// ==== bench/lcr_props.sv ====
// Checker for the register block ports.
`timescale 1ns/1ps
`default_nettype none
module lcr_props (
	input wire logic       MCLK_I,
	input wire logic       RST_N_I,
	input wire logic [7:0] ADDR_I,
	input wire logic [7:0] RDATA_O,
	input wire logic       RUN_O,
	input wire logic       FAST_POWER_UP_SEQUENCE_O,
	input wire logic [7:0] TWARN_CELSIUS_O,
	input wire logic       DOUBLE_WRITE_O
);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	// A stop that is not followed by fast power-up must stay off for eight cycles.
	sequence s_off;
		$fell(RUN_O) ##1 !FAST_POWER_UP_SEQUENCE_O;
	endsequence
	AST_OFF: assert property (s_off |=> !RUN_O [*8])
		else $error("restart without re-arm");
	AST_FAST_UP: assert property (
		$fell(FAST_POWER_UP_SEQUENCE_O) |-> ##[0:1] RUN_O)
		else $error("no run after fast power-up");
	AST_RSTIND: assert property (disable iff (1'b0)
		!RST_N_I ##1 RST_N_I && ADDR_I == 8'h0c |=> RDATA_O == 8'h02)
		else $error("bad value after reset");
	AST_TWARN: assert property (ADDR_I == 8'h0c |=>
		TWARN_CELSIUS_O == 8'h6e + 8'h0a * RDATA_O[5:4])
		else $error("bad threshold");
	AST_DBL: assert property (
		ADDR_I == 8'h0c |=> DOUBLE_WRITE_O == RDATA_O[3])
		else $error("bad protocol select");
	AST_SELFCLR: assert property (RDATA_O[2] |=> !RDATA_O[2])
		else $error("forced reset bit stuck");
endmodule // lcr_props
bind lcr_top lcr_props i_props (.MCLK_I, .RST_N_I, .ADDR_I, .RDATA_O, .RUN_O,
	.FAST_POWER_UP_SEQUENCE_O, .TWARN_CELSIUS_O, .DOUBLE_WRITE_O);
`default_nettype wire

// ==== bench/tb_limits_config_register.sv ====
// Self-checking bench for the limits configuration register.
`timescale 1ns/1ps
`default_nettype none
module tb_limits_config_register;
	logic       clk = 0, rst_n = 0, ts = 0, sc = 0, wr, run, fp, dw;
	logic [7:0] a, d, rd, tw, v;
	logic [1:0] pk;
	int         num_errors = 0, compares = 0, seed = 32'ha050b8d4;
	initial forever #5 clk = ~clk;
	lcr_host i_host (.c_i(clk), .wr_o(wr), .a_o(a), .d_o(d));
	lcr_top i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .WR_I(wr), .ADDR_I(a),
		.WDATA_I(d), .RDATA_O(rd), .THERMAL_SHUTDOWN_I(ts),
		.OUTPUT_SHORT_FAULT_I(sc), .RUN_O(run),
		.FAST_POWER_UP_SEQUENCE_O(fp), .TWARN_CELSIUS_O(tw),
		.PEAK_LIMIT_SEL_O(pk), .DOUBLE_WRITE_O(dw));
	task ck(input string n, input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Expected threshold: 110 degrees for code 0, ten more a step.
	function automatic logic [7:0] exp_twarn(input logic [1:0] c);
		return 8'h6e + 8'h0a * c;
	endfunction
	// The gate takes the write inside the host task; two of these three edges carry it through register and read path.
	task rdck(input logic [7:0] e);
		repeat (3) @(posedge clk);
		#1 ck("reg", rd, e);
		ck("twarn", tw, exp_twarn(e[5:4]));
		ck("dbl", {7'h0, dw}, {7'h0, e[3]});
		ck("peak", {6'h0, pk}, {6'h0, e[7:6]});
	endtask
	task st(input logic [7:0] e, input int n);
		repeat (n) @(posedge clk);
		#1 ck("run", {6'h0, run, fp}, e);
	endtask
	task final_report;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// A hang is cut off far beyond the roughly 130 cycles needed.
	initial begin
		#100000 num_errors++;
		final_report;
	end
	initial begin
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		rdck(8'h02);
		repeat (6) begin
			v = $random(seed) & 8'hf3;
			i_host.wr(8'h0c, v);
			rdck(v);
		end
		i_host.wr(8'h0c, 8'h52);
		rdck(8'h52);
		i_host.wr(8'h0c, 8'ha3);
		rdck(8'ha3);
		i_host.wr(8'h0c, 8'h34);
		rdck(8'h02);
		i_host.wr(8'h0d, 8'h55);
		rdck(8'h02);
		$display("test writes done");
		i_host.wr(8'h0c, 8'h08);
		rdck(8'h08);
		i_host.wr(8'h0c, 8'h31);
		rdck(8'h08);
		i_host.wr(8'h0c, 8'h31);
		rdck(8'h31);
		$display("test double write done");
		i_host.wr(8'h0c, 8'h01);
		rdck(8'h01);
		ts = 1;
		st(8'h01, 3);
		ts = 0;
		st(8'h01, 4);
		st(8'h02, 8);
		rdck(8'h01);
		i_host.wr(8'h0c, 8'h00);
		rdck(8'h00);
		sc = 1;
		st(8'h00, 3);
		sc = 0;
		st(8'h00, 20);
		$display("test faults done");
		rst_n = 0;
		st(8'h00, 2);
		rst_n = 1;
		rdck(8'h02);
		st(8'h02, 1);
		$display("test reset done");
		final_report;
	end
endmodule // tb_limits_config_register
`default_nettype wire
